// *** src/ssp_cycle_div.sv ***
// ssp_cycle_div: instruction-cycle enable divider
// assumes: free-running clk, synchronous reset
`default_nettype none
module ssp_cycle_div #(
  parameter int DIV = ssp_pkg::SSP_INSTR_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic tick,
  output logic half
);
  import ssp_pkg::*;
  logic [SSP_DIV_W-1:0] cnt_ff;
  logic [SSP_DIV_W-1:0] nxt_cnt;
  always_comb begin
    if (cnt_ff == SSP_DIV_W'(DIV - 1)) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + SSP_DIV_W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // tick: end of cycle (rising shift clock), half: mid cycle (falling)
  assign tick = (cnt_ff == SSP_DIV_W'(DIV - 1));
  assign half = (cnt_ff == SSP_DIV_W'(DIV / 2 - 1));
endmodule
`default_nettype wire

// *** src/ssp_master.sv ***
// ssp_master: four-bit serial shift port as synchronous serial master
// assumes: core clk 200 MHz, swap/load strobes one clk wide from the core
// How it works
// - chip select is active low, driven from general output bit zero
// - idle state: select high, shift clock low, serial out low
// - transfers move nibbles; nibble count is the core's loop length
// - in shift mode, swap with carry set starts the shift clock, carry clear stops it
// - a nibble fully shifts within five instruction cycles of a swap
// - serial out shows the top bit only when output enable is set
// - zeros for the peripheral's turnaround gap are left to the core; this port just shifts
// - counter mode counts falling edges on serial input
// - skip test reports zero without changing the register
// - shift mode shifts left, most significant bit first
// - serial input level enters the least significant bit
`default_nettype none
module ssp_master (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ssp_pkg::ssp_swap_req_t acc_shift_swap,
  input wire logic output_port_imm,
  input wire logic [3:0] output_port_val,
  input wire logic load_enable_imm,
  input wire logic [3:0] load_enable_val,
  input wire logic serial_in,
  output logic [3:0] acc_from_shift,
  output logic skip_if_shift_zero,
  output logic [3:0] gen_out,
  output ssp_pkg::ssp_pins_t pins,
  output logic clock_running
);
  import ssp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic tick;
  logic half;
  ssp_cycle_div #(.DIV(SSP_INSTR_CYC)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .half(half)
  );

  // two-stage sync of the pin plus a delay stage; shifting reads the second stage, the fall detect the second and third
  logic si_m_ff;
  logic si_s_ff;
  logic si_d_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      si_m_ff <= 1'b0;
      si_s_ff <= 1'b0;
      si_d_ff <= 1'b0;
    end else begin
      si_m_ff <= serial_in;
      si_s_ff <= si_m_ff;
      si_d_ff <= si_s_ff;
    end
  end
  wire si_fall = si_d_ff & ~si_s_ff;

  ////////////////////////////////////////////////////////////////////
  logic [3:0] shreg_ff;
  logic [3:0] nxt_shreg;
  logic run_ff;
  logic nxt_run;
  logic sclk_ff;
  logic nxt_sclk;
  logic so_ff;
  logic nxt_so;
  logic [3:0] gout_ff;
  logic [3:0] nxt_gout;
  logic [3:0] en_ff;
  logic [3:0] nxt_en;
  logic [3:0] acc_ff;
  logic [3:0] nxt_acc;

  wire counter_mode = en_ff[SSP_EN_CNT_BIT];
  wire so_enable = en_ff[SSP_EN_SO_BIT];

  always_comb begin
    nxt_shreg = shreg_ff;
    nxt_run = run_ff;
    nxt_sclk = sclk_ff;
    nxt_so = so_ff;
    nxt_gout = gout_ff;
    nxt_en = en_ff;
    nxt_acc = acc_ff;
    if (output_port_imm) begin
      nxt_gout = output_port_val;
    end
    if (load_enable_imm) begin
      nxt_en = load_enable_val;
    end
    if (counter_mode) begin
      nxt_sclk = 1'b0;
      if (si_fall) begin
        nxt_shreg = shreg_ff - 4'h1;
      end
    end else if (run_ff) begin
      if (tick) begin
        nxt_sclk = 1'b1;
      end else if (half && sclk_ff) begin
        // only a real falling edge shifts, else a late start would drop a bit
        nxt_sclk = 1'b0;
        // sync is two clks late, so this is the pin as it stood at the rise
        nxt_shreg = {shreg_ff[2:0], si_s_ff};
      end
    end else if (half) begin
      nxt_sclk = 1'b0;
    end
    // output follows the shifted top bit, changes at a falling edge, a swap or an enable load
    nxt_so = so_enable & ~counter_mode & nxt_shreg[3];
    if (acc_shift_swap.swap) begin
      nxt_acc = shreg_ff;
      nxt_shreg = acc_shift_swap.acc;
      nxt_so = so_enable & ~counter_mode & acc_shift_swap.acc[3];
      nxt_run = acc_shift_swap.carry & ~counter_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shreg_ff <= SSP_ZERO;
      run_ff <= 1'b0;
      sclk_ff <= 1'b0;
      so_ff <= 1'b0;
      gout_ff <= SSP_ALL_ONES;
      en_ff <= SSP_ZERO;
      acc_ff <= SSP_ZERO;
    end else begin
      shreg_ff <= nxt_shreg;
      run_ff <= nxt_run;
      sclk_ff <= nxt_sclk;
      so_ff <= nxt_so;
      gout_ff <= nxt_gout;
      en_ff <= nxt_en;
      acc_ff <= nxt_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // gap zeros and nibble count are the core's; this port just shifts
  assign acc_from_shift = acc_ff;
  assign skip_if_shift_zero = (shreg_ff == SSP_ZERO);
  assign gen_out = gout_ff;
  assign pins = '{shift_clock: sclk_ff, shift_out: so_ff, sel_n: gout_ff[0]};
  assign clock_running = run_ff;

  ////////////////////////////////////////////////////////////////////
  // a full nibble leaves within five instruction cycles: count falling edges
  logic [3:0] falls_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      falls_ff <= SSP_ZERO;
    end else if (acc_shift_swap.swap) begin
      falls_ff <= SSP_ZERO;
    end else if (run_ff && sclk_ff && !counter_mode && half && falls_ff != SSP_ALL_ONES) begin
      falls_ff <= falls_ff + 4'h1;
    end
  end

  property p_idle_levels;
    @(posedge clk) disable iff (sys_rst)
      (!run_ff && !counter_mode && half) |=> !sclk_ff;
  endproperty
  a_idle_levels: assert property (p_idle_levels) else $error("clock high while stopped");

  property p_sel_follows;
    @(posedge clk) disable iff (sys_rst)
      output_port_imm |=> pins.sel_n == $past(output_port_val[0]);
  endproperty
  a_sel_follows: assert property (p_sel_follows) else $error("select not from bit zero");

  property p_start_stop;
    @(posedge clk) disable iff (sys_rst)
      acc_shift_swap.swap |=> run_ff == ($past(acc_shift_swap.carry) && !$past(counter_mode));
  endproperty
  a_start_stop: assert property (p_start_stop) else $error("carry gate wrong");

  property p_four_cycles;
    @(posedge clk) disable iff (sys_rst)
      (acc_shift_swap.swap && acc_shift_swap.carry && !counter_mode && !load_enable_imm)
        ##1 (!acc_shift_swap.swap && !load_enable_imm)[*8]
        |-> ##[1:16] (falls_ff >= 4'h4 || acc_shift_swap.swap);
  endproperty
  a_four_cycles: assert property (p_four_cycles) else $error("nibble not shifted in time");

  property p_so_gated;
    @(posedge clk) disable iff (sys_rst)
      !so_enable |=> !pins.shift_out;
  endproperty
  a_so_gated: assert property (p_so_gated) else $error("serial out high while disabled");

  property p_count;
    @(posedge clk) disable iff (sys_rst)
      (counter_mode && si_fall && !acc_shift_swap.swap && !load_enable_imm)
        |=> shreg_ff == $past(shreg_ff) - 4'h1;
  endproperty
  a_count: assert property (p_count) else $error("falling edge not counted");

  property p_skip;
    @(posedge clk) disable iff (sys_rst)
      skip_if_shift_zero |-> shreg_ff == SSP_ZERO;
  endproperty
  a_skip: assert property (p_skip) else $error("skip test wrong");

  property p_shift_left;
    @(posedge clk) disable iff (sys_rst)
      (run_ff && sclk_ff && !counter_mode && half && !tick && !acc_shift_swap.swap)
        |=> shreg_ff == {$past(shreg_ff[2:0]), $past(si_s_ff)};
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("shift wrong");

  property p_so_edge;
    @(posedge clk) disable iff (sys_rst)
      (pins.shift_out != $past(pins.shift_out)) |-> !pins.shift_clock;
  endproperty
  a_so_edge: assert property (p_so_edge) else $error("serial out moved with clock high");

  c_start: cover property (@(posedge clk) disable iff (sys_rst)
    acc_shift_swap.swap && acc_shift_swap.carry);
  c_stop: cover property (@(posedge clk) disable iff (sys_rst)
    run_ff ##1 !run_ff);
  c_count: cover property (@(posedge clk) disable iff (sys_rst)
    counter_mode && si_fall);
  c_select: cover property (@(posedge clk) disable iff (sys_rst)
    !pins.sel_n && pins.shift_clock);
endmodule
`default_nettype wire

// *** src/ssp_pkg.sv ***
// ssp_pkg: shared constants and carrier types for the serial shift port
// assumes: one 200 MHz clock, synchronous active-high reset
`default_nettype none
package ssp_pkg;
  localparam int SSP_NIB_W = 4;
  localparam int SSP_CLK_MHZ = 200;
  localparam int SSP_CYC_NS = 5;
  // instruction cycle length in ns, then in core clocks
  localparam int SSP_INSTR_NS = 20;
  localparam int SSP_INSTR_CYC = (SSP_INSTR_NS + SSP_CYC_NS - 1) / SSP_CYC_NS;
  localparam int SSP_BITS_PER_SWAP = 4;
  localparam int SSP_DEF_NIBBLES = 4;
  localparam int SSP_MAX_NIBBLES = 16;
  localparam logic [3:0] SSP_ZERO = 4'h0;
  localparam logic [3:0] SSP_ALL_ONES = 4'hf;
  localparam logic [3:0] SSP_SEL_ON_VAL = 4'he;
  localparam logic [3:0] SSP_SEL_OFF_VAL = 4'hf;
  localparam logic [3:0] SSP_EN_SHIFT_OUT = 4'h8;
  localparam int SSP_EN_SO_BIT = 3;
  localparam int SSP_EN_CNT_BIT = 2;
  localparam int SSP_DIV_W = 4;
  typedef struct packed {
    logic swap;
    logic carry;
    logic [3:0] acc;
  } ssp_swap_req_t;
  typedef struct packed {
    logic shift_clock;
    logic shift_out;
    logic sel_n;
  } ssp_pins_t;
endpackage
`default_nettype wire

// *** test/ssp_master_tb_top.sv ***
// ssp_master_tb_top: self-checking bench for ssp_master
// assumes: ssp_periph_model as far side; instruction cycle of 4 clks
`default_nettype none
module ssp_master_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ssp_swap_req_t swp = '0;
  logic op_imm = 1'b0;
  logic le_imm = 1'b0;
  logic [3:0] op_val = 4'h0;
  logic [3:0] le_val = 4'h0;
  logic tb_in = 1'b1;
  logic use_model = 1'b0;
  logic [15:0] tx_word = 16'h0;
  logic [15:0] acc_w;
  logic ser_in;
  logic model_out;
  logic [3:0] acc_o;
  logic [3:0] gen_o;
  logic skip_o;
  logic run_o;
  ssp_pins_t pins_o;
  logic [15:0] rx_word;
  logic [5:0] fall_cnt;
  int err_total = 0;
  int cmp_count = 0;
  assign ser_in = use_model ? model_out : tb_in;
  initial forever #2.5 clk = ~clk;
  ssp_master dut_u (.clk(clk), .sys_rst(sys_rst), .acc_shift_swap(swp),
    .output_port_imm(op_imm), .output_port_val(op_val), .load_enable_imm(le_imm),
    .load_enable_val(le_val), .serial_in(ser_in), .acc_from_shift(acc_o),
    .skip_if_shift_zero(skip_o), .gen_out(gen_o), .pins(pins_o), .clock_running(run_o));
  ssp_periph_model partner_u (.clk(clk), .pins(pins_o), .tx_word(tx_word),
    .data_out(model_out), .rx_word(rx_word), .fall_cnt(fall_cnt));
  //////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic port(input logic le, input logic [3:0] v);
    if (le) begin
      le_imm = 1'b1;
      le_val = v;
    end else begin
      op_imm = 1'b1;
      op_val = v;
    end
    step(1);
    if (le)
      le_imm = 1'b0;
    else
      op_imm = 1'b0;
  endtask
  task automatic swap(input logic c, input logic [3:0] a);
    swp = '{swap: 1'b1, carry: c, acc: a};
    step(1);
    swp.swap = 1'b0;
  endtask
  // swap again right after the last fall, before further shifting
  task automatic wait_falls(input int n);
    int i;
    logic hi;
    hi = pins_o.shift_clock;
    for (i = 0; i < 200 && int'(fall_cnt) + int'(hi & ~pins_o.shift_clock) < n; i++) begin
      hi = pins_o.shift_clock;
      step(1);
    end
    if (i == 200) begin
      err_total++;
      conclude();
    end
  endtask
  //////////////////////////////
  initial begin
    void'($urandom(32'he8d8));
    step(2);
    sys_rst = 1'b0;
    cmp({pins_o, gen_o, acc_o, skip_o}, {3'b001, 4'hf, 4'h0, 1'b1});
    for (int p = 0; p < 2; p++) begin
      tx_word = 16'($urandom);
      acc_w = 16'($urandom);
      use_model = 1'b1;
      port(1'b0, SSP_SEL_ON_VAL);
      cmp(16'(pins_o.sel_n), 16'h0);
      port(1'b1, p ? SSP_ZERO : SSP_EN_SHIFT_OUT);
      for (int k = 0; k < 4; k++) begin
        swap(1'b1, acc_w[15-4*k -: 4]);
        if (k > 0)
          cmp(acc_o, tx_word[19-4*k -: 4]);
        wait_falls(4 * k + 4);
      end
      // output disabled on the second pass, so only zeros reach the far side
      cmp(rx_word, p ? 16'h0 : acc_w);
      swap(1'b0, SSP_ZERO);
      cmp(acc_o, tx_word[3:0]);
      step(8);
      cmp({run_o, pins_o.shift_clock}, 2'b00);
      port(1'b0, SSP_SEL_OFF_VAL);
      port(1'b1, SSP_ZERO);
      cmp(pins_o, 3'b001);
    end
    use_model = 1'b0;
    step(1);
    port(1'b1, 4'(1 << SSP_EN_CNT_BIT));
    swap(1'b0, SSP_ZERO);
    step(4);
    cmp(skip_o, 1'b1);
    tb_in = 1'b0;
    step(8);
    tb_in = 1'b1;
    step(8);
    cmp(skip_o, 1'b0);
    swap(1'b0, SSP_ZERO);
    cmp(acc_o, SSP_ALL_ONES);
    conclude();
  end
endmodule
`default_nettype wire

// *** test/ssp_periph_model.sv ***
// ssp_periph_model: far-side serial peripheral, selected by a low select
// assumes: pins come from ssp_master and shift clock edges sit >= 2 clks apart
`default_nettype none
module ssp_periph_model
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire ssp_pkg::ssp_pins_t pins,
  input wire logic [15:0] tx_word,
  output logic data_out,
  output logic [15:0] rx_word,
  output logic [5:0] fall_cnt
);
  logic sc_q = 1'b0;
  logic last_q = 1'b0;
  logic fell;
  initial rx_word = 16'h0;
  initial fall_cnt = 6'h0;
  assign fell = sc_q & ~pins.shift_clock;
  //////////////////////////////
  // next bit shows at the fall, half a shift period before it is sampled
  always_comb begin
    if (pins.sel_n)
      data_out = ~last_q;
    else
      data_out = tx_word[4'(4'hf - fall_cnt[3:0] - 4'(fell))];
  end
  // bits past the data length wrap round and are ignored
  // released line shows the inverse of the last bit driven while selected
  always @(posedge clk) begin
    sc_q <= pins.shift_clock;
    if (!pins.sel_n)
      last_q <= data_out;
    if (pins.sel_n)
      fall_cnt <= 6'h0;
    else if (fell)
      fall_cnt <= fall_cnt + 6'h1;
    if (pins.shift_clock & ~sc_q)
      rx_word <= {rx_word[14:0], pins.shift_out};
  end
endmodule
`default_nettype wire
